// file: shared/isp_pkg.sv
// Shared constants and types for the I2C register slave port.
// Assumes a single system clock domain; the bus pins are asynchronous to it.
package isp_pkg;

  localparam int        ISP_SYNC_STAGES = 3;
  localparam logic [4:0] ISP_ADDR_HIGH  = 5'h13;
  localparam int        ISP_BYTE_BITS   = 8;
  localparam logic [2:0] ISP_BIT_LAST   = 3'h7;
  localparam logic       ISP_DIR_WRITE  = 1'b0;
  localparam logic       ISP_DIR_READ   = 1'b1;

  // Strap levels as seen by the pin sensing logic.
  localparam logic [1:0] ISP_STRAP_GND   = 2'h0;
  localparam logic [1:0] ISP_STRAP_RLOW  = 2'h1;
  localparam logic [1:0] ISP_STRAP_RHIGH = 2'h2;
  localparam logic [1:0] ISP_STRAP_VDD   = 2'h3;

  // Gray coded along idle -> address -> ack -> data.
  typedef enum logic [2:0] {
    ISP_IDLE     = 3'h0,
    ISP_ADDR     = 3'h1,
    ISP_ADDR_ACK = 3'h3,
    ISP_WR_BYTE  = 3'h2,
    ISP_WR_ACK   = 3'h6,
    ISP_RD_BYTE  = 3'h7,
    ISP_RD_ACK   = 3'h5,
    ISP_IGNORE   = 3'h4
  } isp_state_e;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } isp_reg_wr_s;

  typedef struct packed {
    logic       rd;
    logic [7:0] addr;
  } isp_reg_rd_s;

endpackage

// file: src/isp_sync.sv
// Three stage pin synchroniser with agreement filter.
// Assumes the input is asynchronous to clk_sys.
module isp_sync
  import isp_pkg::*;
#(
  parameter logic INIT = 1'b1
) (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic pin,
  output logic      level
);

  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts only once the second and third stages agree.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      level <= INIT;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end

endmodule

// file: src/isp_slave.sv
// I2C slave port giving an external master access to an 8-bit register space.
// Assumes register storage sits outside and answers reads combinationally.
// Operation
// - Answer address whose upper five bits are 10011, lower two from strap.
// - Strap selects 0x4C, 0x4D, 0x4E or 0x4F by its four levels.
// - All bytes are eight bits, most significant bit first.
// - The receiver of each byte returns an acknowledge in the next clock.
// - SDA falling with SCL high is start; rising is stop.
// - Data changes only while SCL is low, stable during SCL high.
// - Device acknowledge holds SDA low for the whole ack clock period.
// - Any number of bytes may follow between start and stop.
// - Device acknowledges a matching address and the pointer byte after it.
// - First write byte sets pointer; later bytes store there and advance it.
// - Device acknowledges every data byte of a multi-byte write.
// - Reads drive bytes from the pointer, advancing while the master acknowledges.
module isp_slave
  import isp_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  arst_n,
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  output logic       sda_o,
  output logic       sda_oe,
  input  wire logic  [1:0] addr_strap,
  output isp_reg_wr_s reg_wr,
  output isp_reg_rd_s reg_rd,
  input  wire logic  [7:0] reg_rdata,
  output logic       busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and bus event detection.

  logic       scl;
  logic       sda;
  logic       scl_q;
  logic       sda_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic [1:0] strap_q;
  logic [1:0] strap;
  logic [1:0] strap_s;

  isp_sync #(.INIT(1'b1)) u_scl (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .pin     (scl_i),
    .level   (scl)
  );

  isp_sync #(.INIT(1'b1)) u_sda (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .pin     (sda_i),
    .level   (sda)
  );

  for (genvar g = 0; g < 2; g++) begin : g_strap
    isp_sync #(.INIT(1'b0)) u_strap (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .pin     (addr_strap[g]),
      .level   (strap_s[g])
    );
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  assign scl_rise  = scl & ~scl_q;
  assign scl_fall  = ~scl & scl_q;
  assign start_det = scl & scl_q & sda_q & ~sda;
  assign stop_det  = scl & scl_q & ~sda_q & sda;

  // The strap is a board level setting; it is tracked while the bus is idle so an
  // address never changes in the middle of a transaction.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      strap_q <= ISP_STRAP_GND;
    end else if (!busy) begin
      strap_q <= strap_s;
    end
  end

  // Maps the sensed strap level onto the address low bits.
  function automatic logic [1:0] strap_bits(input logic [1:0] lvl);
    case (lvl)
      ISP_STRAP_GND:   strap_bits = 2'h0;
      ISP_STRAP_RLOW:  strap_bits = 2'h1;
      ISP_STRAP_RHIGH: strap_bits = 2'h2;
      ISP_STRAP_VDD:   strap_bits = 2'h3;
      default:         strap_bits = 2'h0;
    endcase
  endfunction

  assign strap = strap_bits(strap_q);

  ////////////////////////////////////////////////////////////////////////////
  // Transaction sequencing.

  isp_state_e state;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] pointer;
  logic       have_ptr;
  logic       rd_dir;
  logic       addr_hit;
  logic [7:0] rx_byte;
  logic       ack_live;
  logic       mst_ack;
  logic       in_ack;

  assign rx_byte  = {shreg[6:0], sda};
  assign addr_hit = (shreg[6:0] == {ISP_ADDR_HIGH, strap});
  assign busy     = (state != ISP_IDLE);
  assign in_ack   = (state == ISP_ADDR_ACK) || (state == ISP_WR_ACK) || (state == ISP_RD_ACK);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= ISP_IDLE;
    end else if (start_det) begin
      state <= ISP_ADDR;
    end else if (stop_det) begin
      state <= ISP_IDLE;
    end else begin
      case (state)
        ISP_IDLE: begin
          state <= ISP_IDLE;
        end
        ISP_ADDR: begin
          if (scl_rise && bit_cnt == ISP_BIT_LAST) begin
            state <= addr_hit ? ISP_ADDR_ACK : ISP_IGNORE;
          end
        end
        ISP_ADDR_ACK: begin
          if (scl_fall && ack_live) begin
            state <= rd_dir ? ISP_RD_BYTE : ISP_WR_BYTE;
          end
        end
        ISP_WR_BYTE: begin
          if (scl_rise && bit_cnt == ISP_BIT_LAST) begin
            state <= ISP_WR_ACK;
          end
        end
        ISP_WR_ACK: begin
          if (scl_fall && ack_live) begin
            state <= ISP_WR_BYTE;
          end
        end
        ISP_RD_BYTE: begin
          if (scl_rise && bit_cnt == ISP_BIT_LAST) begin
            state <= ISP_RD_ACK;
          end
        end
        ISP_RD_ACK: begin
          if (scl_fall && ack_live) begin
            state <= mst_ack ? ISP_RD_BYTE : ISP_IGNORE;
          end
        end
        ISP_IGNORE: begin
          state <= ISP_IGNORE;
        end
        default: begin
          state <= ISP_IDLE;
        end
      endcase
    end
  end

  // Bit counter: every byte counts SCL rises, so each ack state opens on the eighth rise.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= 3'h0;
    end else if (start_det || stop_det) begin
      bit_cnt <= 3'h0;
    end else if ((state == ISP_ADDR || state == ISP_WR_BYTE || state == ISP_RD_BYTE) && scl_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // Shift register, MSB first in both directions.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      shreg <= 8'h00;
    end else if ((state == ISP_ADDR || state == ISP_WR_BYTE) && scl_rise) begin
      shreg <= rx_byte;
    end else if (reg_rd.rd) begin
      shreg <= reg_rdata;
    end else if (state == ISP_RD_BYTE && scl_fall) begin
      shreg <= {shreg[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_dir <= ISP_DIR_WRITE;
    end else if (state == ISP_ADDR && scl_rise && bit_cnt == ISP_BIT_LAST) begin
      rd_dir <= (sda == ISP_DIR_READ);
    end
  end

  // The pointer survives a repeated start so a read continues where it was set.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      have_ptr <= 1'b0;
    end else if (start_det || stop_det) begin
      have_ptr <= 1'b0;
    end else if (state == ISP_WR_BYTE && scl_rise && bit_cnt == ISP_BIT_LAST) begin
      have_ptr <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pointer <= 8'h00;
    end else if (state == ISP_WR_BYTE && scl_rise && bit_cnt == ISP_BIT_LAST) begin
      pointer <= have_ptr ? pointer + 8'h01 : rx_byte;
    end else if (state == ISP_RD_ACK && scl_fall && ack_live && mst_ack) begin
      pointer <= pointer + 8'h01;
    end
  end

  // Register side strobes: one cycle each.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_wr <= '0;
    end else begin
      reg_wr.wr   <= (state == ISP_WR_BYTE) && scl_rise && (bit_cnt == ISP_BIT_LAST) && have_ptr;
      reg_wr.addr <= pointer;
      reg_wr.data <= rx_byte;
    end
  end

  // Read address is combinational so reg_rdata is valid when it is captured.
  assign reg_rd.rd   = ((state == ISP_ADDR_ACK) && scl_fall && ack_live && rd_dir) ||
                       ((state == ISP_RD_ACK) && scl_fall && ack_live && mst_ack);
  assign reg_rd.addr = (state == ISP_RD_ACK) ? pointer + 8'h01 : pointer;

  ////////////////////////////////////////////////////////////////////////////
  // SDA drive. Open drain: only ever drives low, changes follow SCL fall.

  logic drive_low;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      drive_low <= 1'b0;
    end else if (start_det || stop_det) begin
      drive_low <= 1'b0;
    end else if (scl_fall) begin
      case (state)
        ISP_ADDR_ACK: drive_low <= ~ack_live | (rd_dir & ~reg_rdata[7]);
        ISP_WR_ACK:   drive_low <= ~ack_live;
        ISP_RD_BYTE:  drive_low <= ~shreg[6];
        ISP_RD_ACK:   drive_low <= ack_live & mst_ack & ~reg_rdata[7];
        default:      drive_low <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge bit tracking.

  // An ack state is entered on the eighth rise and spans two SCL falls: the
  // first opens the ack bit and the second closes it. Keying on falls keeps
  // every SDA change inside the SCL low time.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ack_live <= 1'b0;
    end else if (start_det || stop_det) begin
      ack_live <= 1'b0;
    end else if (in_ack && scl_fall) begin
      ack_live <= ~ack_live;
    end
  end

  // The master's answer to a read byte is taken at the rise of the ack clock.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mst_ack <= 1'b0;
    end else if (state == ISP_RD_ACK && ack_live && scl_rise) begin
      mst_ack <= ~sda;
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = drive_low;

endmodule

// file: tb/isp_slave_checker.sv
// Concurrent checks on the ports of the I2C register slave port.
// Assumes it is bound to isp_slave; the bus pins are asynchronous to clk_sys.
module isp_slave_checker
  import isp_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire isp_reg_wr_s reg_wr,
  input wire isp_reg_rd_s reg_rd,
  input wire logic        busy
);
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic       wr_seen;
  logic       rd_seen;
  logic [7:0] wr_last;
  logic [7:0] rd_last;
  logic       start_seen;
  logic       stop_seen;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  assign start_seen = scl_q[2] & scl_q[1] & sda_q[2] & ~sda_q[1];
  assign stop_seen  = scl_q[2] & scl_q[1] & ~sda_q[2] & sda_q[1];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
    end
  end

  // Address history is dropped at every start so a new pointer never looks like a skip.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_seen <= 1'h0;
      wr_last <= 8'h00;
    end else if (reg_wr.wr) begin
      wr_seen <= 1'h1;
      wr_last <= reg_wr.addr;
    end else if (!busy || start_seen) begin
      wr_seen <= 1'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_seen <= 1'h0;
      rd_last <= 8'h00;
    end else if (reg_rd.rd) begin
      rd_seen <= 1'h1;
      rd_last <= reg_rd.addr;
    end else if (!busy || start_seen) begin
      rd_seen <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////
  AST_OPEN_DRAIN: assert property (!sda_o)
    else $error("sda_o driven high");
  AST_IDLE_RELEASED: assert property (!busy |-> !sda_oe)
    else $error("SDA pulled while idle");
  AST_START_BUSY: assert property (start_seen |-> ##[0:8] busy)
    else $error("start not followed by busy");
  AST_STOP_IDLE: assert property (stop_seen |-> ##[0:8] !busy)
    else $error("stop not followed by idle");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("SDA drive changed while SCL high");
  AST_ACK_HOLD: assert property ($rose(scl_i) && sda_oe |-> sda_oe [*5])
    else $error("SDA drive dropped during SCL high");
  AST_WR_PULSE: assert property (reg_wr.wr |=> !reg_wr.wr)
    else $error("write strobe longer than one cycle");
  AST_WR_IN_TXN: assert property (reg_wr.wr |-> busy)
    else $error("register write outside a transaction");
  AST_WR_STEP: assert property (reg_wr.wr && wr_seen |-> reg_wr.addr == wr_last + 8'h01)
    else $error("write pointer did not advance by one");
  AST_RD_STEP: assert property (reg_rd.rd && rd_seen |-> reg_rd.addr == rd_last + 8'h01)
    else $error("read pointer did not advance by one");
endmodule

bind isp_slave isp_slave_checker i_chk (.clk_sys(clk_sys), .arst_n(arst_n), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .reg_wr(reg_wr), .reg_rd(reg_rd), .busy(busy));

// file: tb/isp_i2c_master.sv
// Behavioural I2C bus master driving SCL and its share of SDA.
// Assumes SDA has a pull-up; sda_m high means released.
module isp_i2c_master (
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda_bus
);
  timeunit 1ns;
  timeprecision 10ps;
  // A quarter of the 125 ns bus clock; SCL stands still between frames.
  localparam realtime Q = 31.25;

  initial begin
    scl = 1'h1;
    sda_m = 1'h1;
  end

  task automatic start();
    sda_m = 1'h1;
    #Q scl = 1'h1;
    #Q sda_m = 1'h0;
    #Q scl = 1'h0;
    #Q;
  endtask

  task automatic stop();
    sda_m = 1'h0;
    #Q scl = 1'h1;
    #Q sda_m = 1'h1;
    #(2 * Q);
  endtask

  task automatic bit_x(input logic b, output logic r);
    sda_m = b;
    #Q scl = 1'h1;
    #Q r = sda_bus;
    #Q scl = 1'h0;
    #Q;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'h1, ack);
  endtask

  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'h1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule

// file: tb/isp_slave_bench.sv
// Self-checking bench for the I2C register slave port.
// Assumes the master model on the bus and a register array behind the port.
module isp_slave_bench
  import isp_pkg::*;
;
  timeunit 1ns;
  timeprecision 10ps;
  logic        clk_sys = 1'h0;
  logic        arst_n = 1'h0;
  logic [1:0]  addr_strap = 2'h0;
  logic [7:0]  reg_rdata;
  logic        scl;
  logic        sda_m;
  logic        sda_o;
  logic        sda_oe;
  logic        sda_bus;
  logic        busy;
  logic [7:0]  p;
  isp_reg_wr_s reg_wr;
  isp_reg_rd_s reg_rd;
  logic [7:0]  mem [256];
  logic [7:0]  model [256];
  int          n;
  int          mismatches = 0;
  int          total_checks = 0;
  int          wr_count = 0;
  int          exp_wr = 0;

  // Pull-up on SDA: the line reads high unless a party pulls it low.
  assign sda_bus = sda_m & ~sda_oe;
  assign reg_rdata = mem[reg_rd.addr];
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (reg_wr.wr === 1'h1) begin
      mem[reg_wr.addr] <= reg_wr.data;
      wr_count <= wr_count + 1;
    end
  end

  isp_slave i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_strap(addr_strap), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .busy(busy));
  isp_i2c_master i_mst (.scl(scl), .sda_m(sda_m), .sda_bus(sda_bus));

  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("Counts: checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_ack(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t ack %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  // A foreign address must be refused on every byte and must store nothing.
  task automatic wr_txn(input logic [6:0] dev, input logic [7:0] ptr, input int cnt, input logic own);
    logic       a;
    logic [7:0] d;
    i_mst.start();
    i_mst.wr_byte({dev, ISP_DIR_WRITE}, a);
    chk_ack(a, !own);
    for (int i = 0; i <= cnt; i++) begin
      d = (i == 0) ? ptr : 8'($urandom);
      i_mst.wr_byte(d, a);
      chk_ack(a, !own);
      if (own && i > 0) begin
        model[8'(ptr + i - 1)] = d;
        exp_wr++;
      end
    end
    i_mst.stop();
  endtask

  task automatic rd_txn(input logic [6:0] dev, input logic [7:0] ptr, input int cnt);
    logic       a;
    logic [7:0] d;
    i_mst.start();
    i_mst.wr_byte({dev, ISP_DIR_WRITE}, a);
    chk_ack(a, 1'h0);
    i_mst.wr_byte(ptr, a);
    chk_ack(a, 1'h0);
    i_mst.start();
    i_mst.wr_byte({dev, ISP_DIR_READ}, a);
    chk_ack(a, 1'h0);
    for (int i = 0; i < cnt; i++) begin
      i_mst.rd_byte(i == cnt - 1, d);
      chk_val(d, model[8'(ptr + i)]);
    end
    i_mst.stop();
  endtask

  initial begin
    void'($urandom(22));
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($urandom);
      model[i] = mem[i];
    end
    repeat (8) @(posedge clk_sys);
    #1 arst_n = 1'h1;
    repeat (8) @(posedge clk_sys);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys);
      #1 addr_strap = 2'(s);
      repeat (4) @(posedge clk_sys);
      p = 8'($urandom);
      wr_txn(7'h4C + 7'(s), p, 2, 1'h1);
      wr_txn(7'h4C + 7'(s ^ 1), p, 2, 1'h0);
      rd_txn(7'h4C + 7'(s), p, 3);
    end
    wr_txn(7'h5F, 8'h10, 1, 1'h0);
    wr_txn(7'h4F, 8'hFE, 4, 1'h1);
    rd_txn(7'h4F, 8'hFD, 5);
    repeat (6) begin
      p = 8'($urandom);
      n = 1 + int'($urandom % 6);
      wr_txn(7'h4F, p, n, 1'h1);
      rd_txn(7'h4F, p, n);
    end
    repeat (20) @(posedge clk_sys);
    chk_val(8'(wr_count), 8'(exp_wr));
    summarize();
  end

  initial begin
    #600000;
    mismatches++;
    summarize();
  end
endmodule
